// [src/clock_control_consts.vh]
/*
  Constants of the clock prescale and source switch control block: register
  offsets, field positions, reset values, command codes and timing counts.
  Assumes it is included by bare name into each design file that needs it.
*/
// Behaviour
// R1: Reserved register bits always read as zero.
// R2: Divider select gives factor two to the code.
// R3: Divider slows all system clocks, rewritable anytime.
// R4: Divider change needs unlock write, then value.
// R5: Software keeps interrupts off during divider change.
// R6: Divider select resets from divide-by-eight fuse.
// R7: Any unlocked divider value is accepted.
// R8: Command unlock set only by lone unlock write.
// R9: Command unlock clears after four cycles or command.
// R10: Rewriting unlock neither restarts nor clears window.
// R11: Commands need unlock then command within four cycles.
// R12: Software keeps interrupts off during command sequence.
// R13: Command codes decode to the seven actions.
// R14: Ready flag clears on availability or enable.
// R15: Ready flag sets when source confirmed stable.
// R16: Software must time out on a dead source.
// R17: Clock output select resets to inverted fuse.
// R18: Clock output select acts only on output command.
// R19: Start-up field resets from fuses, feeds commands.
// R20: Source field resets from fuses, feeds commands.
// R21: Recover command loads current source code.
// R22: Divider unlock set, timed and cleared likewise.
// R23: Division changes glitch-free, never faster than either.
// R24: Watchdog auto-reload stays armed until reset.
// R25: Each accepted command executes exactly once.
`ifndef CLOCK_CONTROL_CONSTS_VH
`define CLOCK_CONTROL_CONSTS_VH

// Byte offsets of the three registers on the 32-bit register bus.
`define OFS_DIVIDER        12'h000
`define OFS_COMMAND        12'h004
`define OFS_SELECTION      12'h008

// Field positions of the divider and command registers; the ready bit is in the command register only.
`define UNLOCK_BIT         7
`define READY_BIT          4
`define FIELD_MSB          3

// Fields of the source selection register.
`define SEL_CLOCK_OUTPUT_SELECT_BIT       6
`define SEL_SUT_MSB        5
`define SEL_SUT_LSB        4
`define SEL_SRC_MSB        3

// Lone unlock write pattern and the reset values of the divider field.
`define UNLOCK_PATTERN     8'h80
`define DIV_RESET_PLAIN    4'h0
`define DIV_RESET_BY_EIGHT 4'h3
`define DIV_MAX_CODE       4'h8

// Window length of both unlock bits, in system clock cycles.
`define UNLOCK_CYCLES      3'h4

// Clock command codes.
`define CMD_NONE           4'h0
`define CMD_DISABLE        4'h1
`define CMD_ENABLE         4'h2
`define CMD_AVAILABILITY   4'h3
`define CMD_SWITCH         4'h4
`define CMD_RECOVER        4'h5
`define CMD_WDT_RELOAD     4'h6
`define CMD_CLOCK_OUT      4'h7

// Bus answers.
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [src/clock_prescale_and_switch_control.v]
/*
  Clock prescale and source switch control: protected divider register,
  protected command register with source-ready flag, source selection
  register, command pulses to the clock switch, and an AXI4-Lite slave.
  Assumes fuse inputs are static, that the clock switch answers on
  current_source_code and source_stable, and that a bus master completes
  the second write of an unlock pair back to back.
*/
`timescale 1ns/10ps
`include "clock_control_consts.vh"

module clock_prescale_and_switch_control #(
  parameter ADDR_W = 12
) (
  // Clock and reset.
  input  wire              aclk,
  input  wire              aresetn,
  // Write address channel.
  input  wire [ADDR_W-1:0] awaddr,
  input  wire [2:0]        awprot,
  input  wire              awvalid,
  output reg               awready,
  // Write data channel.
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  // Write response channel.
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  // Read address channel.
  input  wire [ADDR_W-1:0] araddr,
  input  wire [2:0]        arprot,
  input  wire              arvalid,
  output reg               arready,
  // Read data channel.
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // Configuration fuses, raw bits, zero means programmed.
  input  wire              divide_by_eight_fuse,
  input  wire              clock_output_fuse,
  input  wire [1:0]        startup_time_fuse,
  input  wire [3:0]        source_select_fuse,
  // Answers from the clock switch.
  input  wire [3:0]        current_source_code,
  input  wire              source_stable,
  // Commands to the clock switch.
  output reg  [3:0]        command_source_code,
  output reg  [1:0]        command_startup_code,
  output reg               source_disable_pulse,
  output reg               source_enable_pulse,
  output reg               availability_request_pulse,
  output reg               source_switch_pulse,
  output reg               clock_output_update_pulse,
  output reg               clock_output_enable,
  output reg               watchdog_autoreload_mode,
  // Divided system clock enable.
  output wire              system_clock_tick
);

  // Register state.
  reg [3:0]  divider_select_reg;
  reg [2:0]  divider_window_reg;
  reg [3:0]  clock_command_code_reg;
  reg [2:0]  command_window_reg;
  reg        source_ready_flag_reg;
  reg        ready_pending_reg;
  reg        clock_output_select_reg;
  reg [1:0]  startup_time_code_reg;
  reg [3:0]  source_select_code_reg;

  // Bus holding registers.
  reg [ADDR_W-1:0] wr_addr_reg;
  reg [7:0]        wr_byte_reg;
  reg              wr_lane_reg;

  // Three-stage synchronisers for the clock switch answers.
  reg [4:0]  sync1_reg;
  reg [4:0]  sync2_reg;
  reg [4:0]  sync3_reg;
  reg [3:0]  current_code_reg;
  reg        stable_reg;
  reg        stable_prev_reg;

  // Decoded write strobes.
  wire       do_write;
  wire       wr_divider;
  wire       wr_command;
  wire       wr_selection;
  wire       wr_mapped;
  wire       divider_open;
  wire       command_open;
  wire       accept_divider;
  wire       accept_command;
  wire       stable_rise;
  wire [3:0] cmd;

  // True for a mapped register offset; shared by the read and write paths.
  function is_mapped;
    input [ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `OFS_DIVIDER) || (addr == `OFS_COMMAND) ||
                  (addr == `OFS_SELECTION);
    end
  endfunction

  // True for the lone unlock write, the only value that opens a window.
  function is_unlock;
    input [7:0] value;
    begin
      is_unlock = (value == `UNLOCK_PATTERN);
    end
  endfunction

  // The write is performed once both address and data are held.
  assign do_write     = !awready && !wready && !bvalid;
  assign wr_mapped    = is_mapped(wr_addr_reg);
  assign wr_divider   = do_write && wr_lane_reg && (wr_addr_reg == `OFS_DIVIDER);
  assign wr_command   = do_write && wr_lane_reg && (wr_addr_reg == `OFS_COMMAND);
  assign wr_selection = do_write && wr_lane_reg && (wr_addr_reg == `OFS_SELECTION);
  assign divider_open = (divider_window_reg != 3'h0);
  assign command_open = (command_window_reg != 3'h0);
  assign cmd          = wr_byte_reg[`FIELD_MSB:0];

  // A protected value counts only inside an open window with unlock low.
  assign accept_divider = wr_divider && divider_open &&
                          !wr_byte_reg[`UNLOCK_BIT];            // see R4
  assign accept_command = wr_command && command_open &&
                          !wr_byte_reg[`UNLOCK_BIT];            // see R11
  assign stable_rise    = stable_reg && !stable_prev_reg;

  // Write address and data are taken in either order, then answered.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
      wr_addr_reg <= {ADDR_W{1'b0}};
      wr_byte_reg <= 8'h00;
      wr_lane_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready     <= 1'b0;
        wr_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready      <= 1'b0;
        wr_byte_reg <= wdata[7:0];
        wr_lane_reg <= wstrb[0];
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Reads return the state seen at the cycle the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `OFS_DIVIDER: begin
            rdata <= {24'h00_0000, divider_open, 3'h0,
                      divider_select_reg};                       // see R1
          end
          `OFS_COMMAND: begin
            rdata <= {24'h00_0000, command_open, 2'h0, source_ready_flag_reg,
                      clock_command_code_reg};                   // see R1
          end
          `OFS_SELECTION: begin
            rdata <= {24'h00_0000, 1'b0, clock_output_select_reg,
                      startup_time_code_reg, source_select_code_reg}; // see R1
          end
          default: begin
            rdata <= 32'h0000_0000;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Divider register. The window opens only on the lone unlock value and
  // counts down regardless of further unlock writes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      divider_select_reg <= divide_by_eight_fuse ? `DIV_RESET_PLAIN
                                                 : `DIV_RESET_BY_EIGHT; // see R6
      divider_window_reg <= 3'h0;
    end else begin
      if (accept_divider) begin
        divider_select_reg <= wr_byte_reg[`FIELD_MSB:0];         // see R7
        divider_window_reg <= 3'h0;                              // see R22
      end else if (wr_divider && !divider_open && is_unlock(wr_byte_reg)) begin
        divider_window_reg <= `UNLOCK_CYCLES;                    // see R22
      end else if (divider_open) begin
        divider_window_reg <= divider_window_reg - 3'h1;         // see R22
      end
    end
  end

  // Command register and its unlock window.
  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_command_code_reg <= `CMD_NONE;
      command_window_reg     <= 3'h0;
    end else begin
      if (accept_command) begin
        clock_command_code_reg <= cmd;
        command_window_reg     <= 3'h0;                          // see R9
      end else if (wr_command && !command_open && is_unlock(wr_byte_reg)) begin
        command_window_reg <= `UNLOCK_CYCLES;                    // see R8
      end else if (command_open) begin
        command_window_reg <= command_window_reg - 3'h1;         // see R10
      end
    end
  end

  // Command execution. Every action but recover and watchdog reload is a single pulse
  // the cycle after the accepting write; the stored code is never decoded again, so it cannot retrigger.
  always @(posedge aclk) begin
    if (!aresetn) begin
      source_disable_pulse       <= 1'b0;
      source_enable_pulse        <= 1'b0;
      availability_request_pulse <= 1'b0;
      source_switch_pulse        <= 1'b0;
      clock_output_update_pulse  <= 1'b0;
      clock_output_enable        <= 1'b0;
      watchdog_autoreload_mode   <= 1'b0;
      command_source_code        <= 4'h0;
      command_startup_code       <= 2'h0;
    end else begin
      source_disable_pulse       <= accept_command && (cmd == `CMD_DISABLE); // see R25
      source_enable_pulse        <= accept_command && (cmd == `CMD_ENABLE);  // see R13
      availability_request_pulse <= accept_command && (cmd == `CMD_AVAILABILITY);
      source_switch_pulse        <= accept_command && (cmd == `CMD_SWITCH);
      clock_output_update_pulse  <= accept_command && (cmd == `CMD_CLOCK_OUT);
      // Codes and the start-up field travel with the command they belong to.
      if (accept_command) begin
        command_source_code  <= source_select_code_reg;          // see R20
        command_startup_code <= startup_time_code_reg;           // see R19
      end
      // The output select bit only takes effect through its own command.
      if (accept_command && (cmd == `CMD_CLOCK_OUT)) begin
        clock_output_enable <= clock_output_select_reg;          // see R18
      end
      // Once armed, only a reset leaves auto-reload mode.
      if (accept_command && (cmd == `CMD_WDT_RELOAD)) begin
        watchdog_autoreload_mode <= 1'b1;                        // see R24
      end
    end
  end

  // Selection register: plain writes, and the recover command overwrites
  // only the source field with the code in use.
  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_output_select_reg <= ~clock_output_fuse;             // see R17
      startup_time_code_reg   <= startup_time_fuse;              // see R19
      source_select_code_reg  <= source_select_fuse;             // see R20
    end else begin
      if (accept_command && (cmd == `CMD_RECOVER)) begin
        source_select_code_reg <= current_code_reg;              // see R21
      end else if (wr_selection) begin
        clock_output_select_reg <= wr_byte_reg[`SEL_CLOCK_OUTPUT_SELECT_BIT];
        startup_time_code_reg   <= wr_byte_reg[`SEL_SUT_MSB:`SEL_SUT_LSB];
        source_select_code_reg  <= wr_byte_reg[`SEL_SRC_MSB:0];
      end
    end
  end

  // Answers from the switch cross into this domain through three stages;
  // the stable bit moves only when the second and third stages agree, which
  // filters a single metastable sample; a code bit is cleared whenever they disagree.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg        <= 5'h00;
      sync2_reg        <= 5'h00;
      sync3_reg        <= 5'h00;
      current_code_reg <= 4'h0;
      stable_reg       <= 1'b0;
      stable_prev_reg  <= 1'b0;
    end else begin
      sync1_reg       <= {source_stable, current_source_code};
      sync2_reg       <= sync1_reg;
      sync3_reg       <= sync2_reg;
      stable_prev_reg <= stable_reg;
      current_code_reg <= (current_code_reg & ~(sync2_reg[3:0] ^ sync3_reg[3:0])) |
                          (sync3_reg[3:0] & ~(sync2_reg[3:0] ^ sync3_reg[3:0]));
      if (sync2_reg[4] == sync3_reg[4]) begin
        stable_reg <= sync3_reg[4];
      end
    end
  end

  // Ready flag. A request clears it and arms a wait; it sets on a fresh
  // confirmation, or on a standing one once the wait is armed. The set
  // wins in a cycle where both happen, so no confirmation is lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      source_ready_flag_reg <= 1'b0;
      ready_pending_reg     <= 1'b0;
    end else begin
      if (stable_rise || (ready_pending_reg && stable_reg)) begin
        source_ready_flag_reg <= 1'b1;                           // see R15
        ready_pending_reg     <= 1'b0;
      end else if (accept_command &&
                   ((cmd == `CMD_AVAILABILITY) || (cmd == `CMD_ENABLE))) begin
        source_ready_flag_reg <= 1'b0;                           // see R14
        ready_pending_reg     <= 1'b1;
      end
    end
  end

  // The prescaler sits in its own module so the glitch-free period logic
  // can be reused for other divided enables.
  clock_prescaler #(
    .CNT_W (8)
  ) prescaler_inst (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .divider_select (divider_select_reg),                        // see R3
    .tick_reg       (system_clock_tick)
  );

endmodule

// [src/clock_prescaler.v]
/*
  Power-of-two system clock prescaler producing a one-cycle clock enable tick.
  Assumes the select input comes from a register on the same clock and that
  downstream logic uses the tick as its clock enable.
*/
`timescale 1ns/10ps
`include "clock_control_consts.vh"

module clock_prescaler #(
  parameter CNT_W = 8
) (
  // Clock and reset.
  input  wire             aclk,
  input  wire             aresetn,
  // Requested division code.
  input  wire [3:0]       divider_select,
  // Divided clock enable.
  output reg              tick_reg
);

  reg [3:0]       active_reg;
  reg [CNT_W-1:0] count_reg;
  wire            period_end;

  // Terminal count for a code; reserved codes run at the slowest factor.
  function [CNT_W-1:0] term_count;
    input [3:0] code;
    reg   [3:0] c;
    begin
      c = (code > `DIV_MAX_CODE) ? `DIV_MAX_CODE : code; // see R2
      term_count = (({{(CNT_W-1){1'b0}}, 1'b1} << c) - {{(CNT_W-1){1'b0}}, 1'b1});
    end
  endfunction

  assign period_end = (count_reg == term_count(active_reg));

  // A new factor is taken only when the running period has ended, so no
  // shortened period can appear between the old and new rates.
  always @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= `DIV_RESET_PLAIN;
      count_reg  <= {CNT_W{1'b0}};
      tick_reg   <= 1'b0;
    end else begin
      tick_reg <= period_end;                         // see R3
      if (period_end) begin
        active_reg <= divider_select;                 // see R23
        count_reg  <= {CNT_W{1'b0}};
      end else begin
        count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [verif/clock_prescale_and_switch_control_asserts.sv]
/*
  Checker for the clock prescale and source switch control block.
  Sees only the top module's ports and is attached by the bind at the foot.
*/
`timescale 1ns/10ps
`include "clock_control_consts.vh"

module clock_prescale_and_switch_control_asserts #(
  parameter ADDR_W = 12
) (
  // Clock and reset.
  input logic              aclk,
  input logic              aresetn,
  // Bus handshakes.
  input logic              wvalid,
  input logic              wready,
  input logic [ADDR_W-1:0] araddr,
  input logic              arvalid,
  input logic              arready,
  input logic [31:0]       rdata,
  input logic              rvalid,
  // Clock switch commands.
  input logic [3:0]        command_source_code,
  input logic [1:0]        command_startup_code,
  input logic              source_disable_pulse,
  input logic              source_enable_pulse,
  input logic              availability_request_pulse,
  input logic              source_switch_pulse,
  input logic              clock_output_update_pulse,
  input logic              clock_output_enable,
  input logic              watchdog_autoreload_mode
);
  logic [3:0]        since_w;
  logic [ADDR_W-1:0] rd_addr_reg;
  wire  [4:0]        pulses = {clock_output_update_pulse, source_switch_pulse,
                               availability_request_pulse, source_enable_pulse,
                               source_disable_pulse};

  // Age of the last data beat; it saturates so a long idle spell never wraps.
  always @(posedge aclk) begin
    if (!aresetn)
      since_w <= 4'hf;
    else if (wvalid && wready)
      since_w <= 4'h0;
    else if (since_w != 4'hf)
      since_w <= since_w + 4'h1;
  end

  // Address of the read in flight, so read data can be judged per register.
  always @(posedge aclk) begin
    if (arvalid && arready)
      rd_addr_reg <= araddr;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rd_reserved;
    rvalid |-> (rd_addr_reg == `OFS_DIVIDER ? rdata[6:4] == 3'h0 :
                rd_addr_reg == `OFS_COMMAND ? rdata[6:5] == 2'h0 :
                rd_addr_reg == `OFS_SELECTION ? rdata[7] == 1'b0 : 1'b1);
  endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bit read as one");

  property p_pulse_once;
    |pulses |=> !(|pulses);
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("command pulse repeated");

  property p_onehot;
    $onehot0(pulses);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two command pulses at once");

  property p_pulse_cause;
    |pulses |-> since_w <= 4'h4;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without a write");

  property p_wdt_sticky;
    watchdog_autoreload_mode |=> watchdog_autoreload_mode;
  endproperty
  a_wdt_sticky: assert property (p_wdt_sticky) else $error("watchdog mode dropped");

  property p_wdt_cause;
    $rose(watchdog_autoreload_mode) |-> since_w <= 4'h4;
  endproperty
  a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog mode without write");

  property p_clkout_cause;
    $changed(clock_output_enable) |->
      clock_output_update_pulse || $past(clock_output_update_pulse);
  endproperty
  a_clkout_cause: assert property (p_clkout_cause) else $error("output enable moved alone");

  property p_code_cause;
    $changed({command_source_code, command_startup_code}) |-> since_w <= 4'h4;
  endproperty
  a_code_cause: assert property (p_code_cause) else $error("command codes moved alone");

  c_switch: cover property (source_switch_pulse);
  c_wdt: cover property ($rose(watchdog_autoreload_mode));
  c_clkout: cover property (clock_output_update_pulse);
endmodule

bind clock_prescale_and_switch_control clock_prescale_and_switch_control_asserts #(
  .ADDR_W(ADDR_W)
) i_asserts (
  .aclk(aclk), .aresetn(aresetn), .wvalid(wvalid), .wready(wready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .command_source_code(command_source_code), .command_startup_code(command_startup_code),
  .source_disable_pulse(source_disable_pulse), .source_enable_pulse(source_enable_pulse),
  .availability_request_pulse(availability_request_pulse),
  .source_switch_pulse(source_switch_pulse),
  .clock_output_update_pulse(clock_output_update_pulse),
  .clock_output_enable(clock_output_enable), .watchdog_autoreload_mode(watchdog_autoreload_mode)
);

// [verif/clock_prescale_and_switch_control_tb_top.sv]
/*
  Self-checking bench for the clock prescale and source switch control block.
  Assumes bready and rready stay high throughout.
*/
`timescale 1ns/10ps

module clock_prescale_and_switch_control_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready = 1'b1;
  logic        rready = 1'b1;
  logic        dfuse = 1'b0;
  logic        ofuse = 1'b0;
  logic [1:0]  sut_fuse = 2'h2;
  logic [3:0]  src_fuse = 4'h9;
  logic [3:0]  cur_src = 4'h0;
  logic        stable = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, clk_out_en, wdt_mode, tick;
  wire  [1:0]  bresp, rresp, cmd_sut;
  wire  [31:0] rdata;
  wire  [3:0]  cmd_src;
  wire  [4:0]  pv;
  logic [7:0]  sel_m, rd_v;
  logic [1:0]  resp;
  integer      error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'h42bd, i, c, n;
  integer      pc [5], ex [5];

  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;

  clock_prescale_and_switch_control i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .divide_by_eight_fuse(dfuse), .clock_output_fuse(ofuse),
    .startup_time_fuse(sut_fuse), .source_select_fuse(src_fuse),
    .current_source_code(cur_src), .source_stable(stable), .command_source_code(cmd_src),
    .command_startup_code(cmd_sut), .source_disable_pulse(pv[0]),
    .source_enable_pulse(pv[1]), .availability_request_pulse(pv[2]),
    .source_switch_pulse(pv[3]), .clock_output_update_pulse(pv[4]),
    .clock_output_enable(clk_out_en), .watchdog_autoreload_mode(wdt_mode),
    .system_clock_tick(tick));

  // Pulse counters and the hang limit; a stuck handshake would otherwise never end.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn) for (int k = 0; k < 5; k++) pc[k] <= pc[k] + 32'(pv[k]);
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // Called just after an edge; address and data drop on their own handshakes.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata[7:0];
        r = rresp;
        break;
      end
    end
  endtask

  task automatic cmd(input logic [7:0] v);
    logic [1:0] r;
    wr(12'h004, 8'h80, r);
    wr(12'h004, v, r);
  endtask

  // Cycles from one divided tick to the next.
  task automatic gap(output integer g);
    g = 0;
    while (tick !== 1'b1) @(posedge aclk);
    do begin
      @(posedge aclk);
      g++;
    end while (tick !== 1'b1);
  endtask

  task automatic report_and_stop();
    $display("Checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence.
  initial begin
    for (i = 0; i < 5; i++) begin
      pc[i] = 0;
      ex[i] = 0;
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, rd_v, resp);
    chk(rd_v, 8'h03);
    rd(12'h004, rd_v, resp);
    chk(rd_v, 8'h00);
    rd(12'h008, rd_v, resp);
    chk(rd_v, 8'h69);
    $display("reset value test done");
    wr(12'h000, 8'h07, resp);
    rd(12'h000, rd_v, resp);
    chk(rd_v, 8'h03);
    for (c = 0; c < 9; c++) begin
      wr(12'h000, 8'h80, resp);
      wr(12'h000, 8'h70 | 8'(c), resp);
      rd(12'h000, rd_v, resp);
      chk(rd_v, 8'(c));
      repeat (3) gap(n);
      chk(n, 1 << c);
    end
    wr(12'h000, 8'h80, resp);
    repeat (6) @(posedge aclk);
    wr(12'h000, 8'h02, resp);
    rd(12'h000, rd_v, resp);
    chk(rd_v, 8'h08);
    $display("divider test done");
    for (c = 1; c < 8; c++) begin
      sel_m = 8'($random(seed)) & 8'h7f;
      cur_src <= 4'($random(seed));
      wr(12'h008, sel_m, resp);
      cmd(8'(c));
      repeat (4) @(posedge aclk);
      if (c < 5) ex[c-1]++;
      if (c == 7) ex[4]++;
      for (i = 0; i < 5; i++) chk(pc[i], ex[i]);
      if (c < 5) begin
        chk(cmd_src, sel_m[3:0]);
        chk(cmd_sut, sel_m[5:4]);
      end
      if (c == 5) sel_m[3:0] = cur_src;
      rd(12'h008, rd_v, resp);
      chk(rd_v, sel_m);
      if (c == 6) chk(wdt_mode, 1'b1);
      if (c == 7) chk(clk_out_en, sel_m[6]);
    end
    $display("command test done");
    cmd(8'h09);
    cmd(8'h00);
    wr(12'h004, 8'h02, resp);
    wr(12'h004, 8'h81, resp);
    wr(12'h004, 8'h02, resp);
    wr(12'h004, 8'h80, resp);
    wr(12'h004, 8'h80, resp);
    wr(12'h004, 8'h02, resp);
    wr(12'h004, 8'h80, resp);
    repeat (4) @(posedge aclk);
    wr(12'h004, 8'h02, resp);
    repeat (4) @(posedge aclk);
    for (i = 0; i < 5; i++) chk(pc[i], ex[i]);
    $display("refusal test done");
    cmd(8'h02);
    ex[1]++;
    repeat (4) @(posedge aclk);
    rd(12'h004, rd_v, resp);
    chk(rd_v, 8'h02);
    stable <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(12'h004, rd_v, resp);
    chk(rd_v, 8'h12);
    chk(pc[1], ex[1]);
    $display("ready flag test done");
    wr(12'h010, 8'h80, resp);
    chk(resp, 2'h2);
    rd(12'h010, rd_v, resp);
    chk(resp, 2'h2);
    $display("unmapped test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(wdt_mode, 1'b0);
    rd(12'h000, rd_v, resp);
    chk(rd_v, 8'h03);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
